// ---- core/erc_consts.svh ----
// constants for the selected error record control block
`ifndef ERC_CONSTS_SVH
`define ERC_CONSTS_SVH
// ============================================================
// system register encoding
`define ERC_OP0 2'h3
`define ERC_OP1 3'h0
`define ERC_CRN 4'h5
`define ERC_CRM 4'h4
`define ERC_OP2 3'h1
// ============================================================
// control word field positions
`define ERC_BIT_ED 0
`define ERC_BIT_UI 2
`define ERC_BIT_FI 3
`define ERC_BIT_CFI 8
// ============================================================
// record count, reset value, syndrome class
`define ERC_NUM_RECORDS 2
`define ERC_SEL_W 1
`define ERC_ENABLE_RESET 4'h0
`define ERC_TRAP_CLASS 6'h18
`define ERC_CNT_W 8
`define ERC_CNT_MAX 8'hFF
`endif

// ---- core/erc_pkg.sv ----
// types for the selected error record control block
package erc_pkg;
    // exception level of the access
    typedef enum logic [1:0] {ERC_EL0, ERC_EL1, ERC_EL2, ERC_EL3} erc_level_t;
    // outcome of an access check
    typedef enum logic [1:0] {ERC_OK, ERC_UNDEF, ERC_TRAP_EL2, ERC_TRAP_EL3} erc_result_t;
endpackage

// ---- core/erc_record_enables.sv ----
// per-record enable bits and error event gating for one record
`timescale 1ns/10ps
`include "erc_consts.svh"
module erc_record_enables (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic wrEn,
    input wire logic [3:0] wrBits,
    output logic [3:0] enBits,
    input wire logic errCorrected,
    input wire logic errDeferred,
    input wire logic errUncorrected,
    output logic faultIrq,
    output logic recoveryIrq,
    output logic [`ERC_CNT_W-1:0] ceCount,
    output logic ceOverflow
);
    // ============================================================
    // enable storage: {cfi, fi, ui, ed}
    logic [3:0] enables_reg;
    logic [3:0] enables_next;
    logic [`ERC_CNT_W-1:0] count_reg;
    logic [`ERC_CNT_W-1:0] count_next;
    logic ovf_reg;
    logic ovf_next;
    logic ceWrap;
    wire logic detEn = enables_reg[0]; // detection gate
    wire logic uiEn = enables_reg[1];
    wire logic fiEn = enables_reg[2];
    wire logic cfiEn = enables_reg[3];

    // events seen only while detection is on; direction is not separated
    wire logic ceSeen = errCorrected & detEn;
    wire logic deSeen = errDeferred & detEn;
    wire logic ueSeen = errUncorrected & detEn;

    assign enables_next = wrEn ? wrBits : enables_reg;
    assign ceWrap = ceSeen && (count_reg == `ERC_CNT_MAX);
    assign count_next = ceSeen ? count_reg + 8'h01 : count_reg;
    // overflow flag is sticky; only the cold reset on sys_rst clears it
    assign ovf_next = ovf_reg | ceWrap;

    // ============================================================
    // only the async cold reset clears; warm reset is not wired here on purpose
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            enables_reg <= `ERC_ENABLE_RESET;
            count_reg <= 8'h00;
            ovf_reg <= 1'b0;
        end else begin
            enables_reg <= enables_next;
            count_reg <= count_next;
            ovf_reg <= ovf_next;
        end
    end

    // interrupts are raised regardless of whether the syndrome is recorded,
    // so a lower priority error still interrupts
    assign faultIrq = (fiEn & (deSeen | ueSeen)) | (cfiEn & ceWrap);
    assign recoveryIrq = uiEn & ueSeen & ~deSeen;
    assign enBits = enables_reg;
    assign ceCount = count_reg;
    assign ceOverflow = ovf_reg;
endmodule // erc_record_enables

// ---- core/erc_control_reg.sv ----
// selected error record control register with access checks
// Behaviour
// - access goes to selected record control
// - cfi raises fault irq on counter overflow
// - irq raised even when syndrome dropped
// - fi raises fault irq for deferred/uncorrected
// - ui raises recovery irq for uncorrected without deferred
// - ed gates detection and correction
// - enables cover reads and writes alike
// - cold reset clears enables, warm keeps
// - lowest level access is undefined
// - el2 error trap bit traps first
// - fine grain read trap to el2
// - fine grain write trap to el2
// - monitor trap bit traps to el3
// - highest level always accesses
// - decode op0 3 op1 0 crn5 crm4 op2 1
// - eight bit corrected error counter per record, on ceCounts
`timescale 1ns/10ps
`include "erc_consts.svh"
module erc_control_reg
    import erc_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    // system register instruction from the core
    input wire logic sysregValid,
    input wire logic sysregWrite,
    input wire logic [1:0] sysregOp0,
    input wire logic [2:0] sysregOp1,
    input wire logic [3:0] sysregCrn,
    input wire logic [3:0] sysregCrm,
    input wire logic [2:0] sysregOp2,
    input wire logic [63:0] sysregWdata,
    input wire erc_level_t curLevel,
    // trap controls
    input wire logic el2Enabled,
    input wire logic hypErrorRegTrap,
    input wire logic monitorErrorRegTrap,
    input wire logic fineGrainTrapEnable,
    input wire logic fineGrainReadTrap,
    input wire logic fineGrainWriteTrap,
    input wire logic [`ERC_SEL_W-1:0] errorRecordSelector,
    // error events, one bit per record
    input wire logic [`ERC_NUM_RECORDS-1:0] errCorrected,
    input wire logic [`ERC_NUM_RECORDS-1:0] errDeferred,
    input wire logic [`ERC_NUM_RECORDS-1:0] errUncorrected,
    // answer to the core
    output logic respValid,
    output erc_result_t respResult,
    output logic [5:0] respClass,
    output logic [63:0] respRdata,
    // outward signals
    output logic [`ERC_NUM_RECORDS-1:0] detectCorrectEnable,
    output logic faultIrq,
    output logic recoveryIrq,
    output logic [`ERC_NUM_RECORDS*`ERC_CNT_W-1:0] ceCounts,
    output logic [`ERC_NUM_RECORDS-1:0] ceOverflows
);
    // ============================================================
    // instruction decode
    // each encoding field is compared on its own, which keeps the match
    // readable when a foreign encoding has to be traced on a waveform
    wire logic op0Match = (sysregOp0 == `ERC_OP0);
    wire logic op1Match = (sysregOp1 == `ERC_OP1);
    wire logic crnMatch = (sysregCrn == `ERC_CRN);
    wire logic crmMatch = (sysregCrm == `ERC_CRM);
    wire logic op2Match = (sysregOp2 == `ERC_OP2);
    // reads and writes share one encoding; the direction comes from sysregWrite
    wire logic encMatch = op0Match && op1Match && crnMatch && crmMatch && op2Match;
    // a request is taken only with the strobe; other encodings are not ours to answer
    wire logic hit = sysregValid && encMatch;
    wire logic isRead = !sysregWrite; // read direction of the request

    // ============================================================
    // trap causes, one named wire each
    // the el2 error register trap bit only counts while the second level runs
    wire logic hypTrapOn = el2Enabled && hypErrorRegTrap;
    // fine grain traps need the second level and the monitor's global enable
    wire logic fgGate = el2Enabled && fineGrainTrapEnable;
    // only the fine grain bit of the access direction applies
    wire logic fgReadTrapOn = fgGate && isRead && fineGrainReadTrap;
    wire logic fgWriteTrapOn = fgGate && sysregWrite && fineGrainWriteTrap;
    wire logic fgTrapOn = fgReadTrapOn || fgWriteTrapOn;
    // the monitor bit is the last resort at both lower privileged levels
    wire logic monTrapOn = monitorErrorRegTrap;

    // ============================================================
    // access check
    // outcome of the access; the el2 trap bit wins over fine grain,
    // which wins over the monitor bit
    erc_result_t check;
    always_comb begin
        unique case (curLevel)
            // least privileged level never reaches the register
            ERC_EL0: check = ERC_UNDEF;
            ERC_EL1: begin
                if (hypTrapOn) begin
                    check = ERC_TRAP_EL2;
                end else if (fgTrapOn) begin
                    check = ERC_TRAP_EL2;
                end else if (monTrapOn) begin
                    check = ERC_TRAP_EL3;
                end else begin
                    check = ERC_OK;
                end
            end
            // second level answers only to the monitor bit
            ERC_EL2: check = monTrapOn ? ERC_TRAP_EL3 : ERC_OK;
            // highest level is never trapped
            ERC_EL3: check = ERC_OK;
        endcase
    end
    // a taken request that passed every check
    wire logic accOk = hit && (check == ERC_OK);
    // trapped or undefined writes leave the enables alone
    wire logic doWrite = accOk && sysregWrite;
    // only the four enable positions are picked out; reserved bits are dropped here
    wire logic [3:0] wrBits = {sysregWdata[`ERC_BIT_CFI], sysregWdata[`ERC_BIT_FI],
        sysregWdata[`ERC_BIT_UI], sysregWdata[`ERC_BIT_ED]};

    // ============================================================
    // one enable set per record
    // enables of each record, {cfi, fi, ui, ed}
    logic [3:0] enArr [`ERC_NUM_RECORDS];
    logic [`ERC_NUM_RECORDS-1:0] fIrq; // fault irq of each record
    logic [`ERC_NUM_RECORDS-1:0] rIrq; // recovery irq of each record
    genvar gi;
    generate
        for (gi = 0; gi < `ERC_NUM_RECORDS; gi++) begin : g_rec
            // writes reach only the selected record
            wire logic selHit = doWrite && (errorRecordSelector == gi);
            erc_record_enables u_rec (
                .core_clk(core_clk),
                .sys_rst(sys_rst),
                .wrEn(selHit),
                .wrBits(wrBits),
                .enBits(enArr[gi]),
                .errCorrected(errCorrected[gi]),
                .errDeferred(errDeferred[gi]),
                .errUncorrected(errUncorrected[gi]),
                .faultIrq(fIrq[gi]),
                .recoveryIrq(rIrq[gi]),
                .ceCount(ceCounts[gi*`ERC_CNT_W +: `ERC_CNT_W]),
                .ceOverflow(ceOverflows[gi])
            );
            assign detectCorrectEnable[gi] = enArr[gi][0];
        end
    endgenerate
    // every record shares one pair of interrupt lines; a handler finds
    // the source by stepping the selector through the records
    assign faultIrq = |fIrq;
    // recovery line merged the same way
    assign recoveryIrq = |rIrq;

    // read view of the selected record; reserved bits zero
    // with two records the selector is one bit, so no index can fall outside
    logic [3:0] selEn;
    assign selEn = enArr[errorRecordSelector];
    logic [63:0] rdView;
    always_comb begin
        rdView = 64'h0;
        rdView[`ERC_BIT_ED] = selEn[0];
        rdView[`ERC_BIT_UI] = selEn[1];
        rdView[`ERC_BIT_FI] = selEn[2];
        rdView[`ERC_BIT_CFI] = selEn[3];
    end

    // ============================================================
    // answer registers: one cycle after the request
    // next values are named so that each flip-flop block stays short
    wire logic respValid_next = hit;
    // a trap answer carries the system access class, anything else zero
    wire logic isTrap = (check == ERC_TRAP_EL2) || (check == ERC_TRAP_EL3);
    wire logic [5:0] respClass_next = isTrap ? `ERC_TRAP_CLASS : 6'h00;
    // data is only exposed on a permitted read, so a trapped read leaks nothing
    wire logic [63:0] respRdata_next = (accOk && isRead) ? rdView : 64'h0;
    logic respValid_reg; // answer strobe, high for one cycle
    erc_result_t respResult_reg; // outcome of the access check
    logic [5:0] respClass_reg; // syndrome class of a trap
    logic [63:0] respRdata_reg; // read word of a permitted read

    // answer strobe; a foreign encoding leaves it low
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            respValid_reg <= 1'b0;
        end else begin
            respValid_reg <= respValid_next;
        end
    end

    // access outcome, updated every cycle; only meaningful with the strobe
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            respResult_reg <= ERC_OK;
        end else begin
            respResult_reg <= check;
        end
    end

    // syndrome class of a trapped access
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            respClass_reg <= 6'h00;
        end else begin
            respClass_reg <= respClass_next;
        end
    end

    // read word; the enables are seen as they stood before the taking edge
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            respRdata_reg <= 64'h0;
        end else begin
            respRdata_reg <= respRdata_next;
        end
    end

    // answer ports are straight flip-flop outputs
    assign respValid = respValid_reg;
    assign respResult = respResult_reg;
    assign respClass = respClass_reg;
    assign respRdata = respRdata_reg;
endmodule // erc_control_reg

// ---- test/erc_control_reg_checker.sv ----
// port checker for the selected error record control register
`timescale 1ns/10ps
module erc_control_reg_checker
    import erc_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic sysregValid,
    input wire erc_level_t curLevel,
    input wire logic el2Enabled,
    input wire logic hypErrorRegTrap,
    input wire logic monitorErrorRegTrap,
    input wire logic [1:0] errDeferred,
    input wire logic [1:0] errUncorrected,
    input wire logic respValid,
    input wire erc_result_t respResult,
    input wire logic [5:0] respClass,
    input wire logic faultIrq,
    input wire logic recoveryIrq,
    input wire logic [1:0] detectCorrectEnable,
    input wire logic [1:0] ceOverflows
);
    // ==========
    // answers and irqs, one clock domain
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // a trap answer carries its class code
    sequence s_trap(erc_result_t r); respResult == r && respClass == 6'h18; endsequence
    property p_answer; respValid |-> $past(sysregValid); endproperty
    a_answer: assert property (p_answer) else $error("answer without request");
    property p_undef; respValid && $past(curLevel) == ERC_EL0
        |-> respResult == ERC_UNDEF; endproperty
    a_undef: assert property (p_undef) else $error("lowest level not refused");
    property p_hyp; respValid && $past(curLevel == ERC_EL1 && el2Enabled && hypErrorRegTrap)
        |-> s_trap(ERC_TRAP_EL2); endproperty
    a_hyp: assert property (p_hyp) else $error("hyp trap missed");
    property p_mon; respValid && $past(curLevel == ERC_EL2 && monitorErrorRegTrap)
        |-> s_trap(ERC_TRAP_EL3); endproperty
    a_mon: assert property (p_mon) else $error("monitor trap missed");
    property p_top; respValid && $past(curLevel) == ERC_EL3 |-> respResult == ERC_OK; endproperty
    a_top: assert property (p_top) else $error("top level refused");
    property p_rec; recoveryIrq
        |-> |(errUncorrected & ~errDeferred & detectCorrectEnable); endproperty
    a_rec: assert property (p_rec) else $error("stray recovery irq");
    // without a deferred or uncorrected cause the fault irq must be a counter wrap
    property p_fault; faultIrq && !(|((errDeferred | errUncorrected) & detectCorrectEnable))
        |=> |ceOverflows; endproperty
    a_fault: assert property (p_fault) else $error("stray fault irq");
    property p_off; detectCorrectEnable == 2'h0 |-> !faultIrq && !recoveryIrq; endproperty
    a_off: assert property (p_off) else $error("irq with detection off");
endmodule // erc_control_reg_checker
bind erc_control_reg erc_control_reg_checker chk (.*);

// ---- test/erc_core_model.sv ----
// core model issuing system register instructions
`timescale 1ns/10ps
module erc_core_model
    import erc_pkg::*;
(
    input wire logic core_clk,
    output logic sysregValid,
    output logic sysregWrite,
    output logic [1:0] sysregOp0,
    output logic [2:0] sysregOp1,
    output logic [3:0] sysregCrn,
    output logic [3:0] sysregCrm,
    output logic [2:0] sysregOp2,
    output logic [63:0] sysregWdata,
    output erc_level_t curLevel
);
    // ==========
    // one instruction, held across the edge that takes it
    task automatic issue(input logic wr, input erc_level_t lv, input logic [63:0] d,
        input logic [15:0] enc);
        @(posedge core_clk);
        #1;
        {sysregOp0, sysregOp1, sysregCrn, sysregCrm, sysregOp2} = enc;
        {sysregWrite, sysregWdata} = {wr, d};
        curLevel = lv;
        sysregValid = 1'h1;
        @(posedge core_clk);
        #1;
        sysregValid = 1'h0;
        // released fields show the inverse so a stale value never looks valid
        {sysregOp0, sysregOp1, sysregCrn, sysregCrm, sysregOp2, sysregWdata} = ~{enc, d};
    endtask
    initial begin
        {sysregValid, sysregWrite, sysregOp0, sysregOp1, sysregCrn, sysregCrm} = 15'h0;
        {sysregOp2, sysregWdata} = 67'h0;
        curLevel = ERC_EL0;
    end
endmodule // erc_core_model

// ---- test/error_record_control_reg_test.sv ----
// self-checking bench for the selected error record control register
`timescale 1ns/10ps
module error_record_control_reg_test
    import erc_pkg::*;
;
    logic core_clk, sys_rst, sysregValid, sysregWrite, el2Enabled, hypErrorRegTrap, faultIrq;
    logic monitorErrorRegTrap, fineGrainTrapEnable, fineGrainReadTrap, fineGrainWriteTrap;
    logic respValid, recoveryIrq, errorRecordSelector;
    logic [1:0] sysregOp0, errCorrected, errDeferred, errUncorrected, detectCorrectEnable;
    logic [1:0] ceOverflows;
    logic [2:0] sysregOp1, sysregOp2;
    logic [3:0] sysregCrn, sysregCrm;
    logic [5:0] respClass;
    logic [15:0] ceCounts;
    logic [63:0] sysregWdata, respRdata;
    erc_level_t curLevel;
    erc_result_t respResult;
    int mismatches = 0;
    int cmp_count = 0;
    erc_control_reg dut (.*);
    erc_core_model core (.*);
    // ==========
    // clock, compare and verdict
    initial begin
        core_clk = 1'h0;
        forever #20 core_clk = ~core_clk;
    end
    task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL %0t %s", $time, what);
        end
    endtask
    task automatic finish_test;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // matching instruction, then its one-cycle answer
    task automatic acc(input logic wr, input erc_level_t lv, input logic [63:0] d,
        input erc_result_t res, input logic [63:0] rd);
        core.issue(wr, lv, d, 16'hC2A1);
        check({respValid, respResult, respClass},
            {1'h1, res, res > ERC_UNDEF ? 6'h18 : 6'h0}, "answer");
        check(respRdata, rd, "read word");
    endtask
    // error event for one cycle; irqs are combinational, so look inside that cycle
    task automatic ev(input logic [3:0] deUe, input logic [1:0] irqs);
        @(posedge core_clk);
        #1 {errDeferred, errUncorrected} = deUe;
        #5 check({faultIrq, recoveryIrq}, irqs, "irqs");
        @(posedge core_clk);
        #1 {errDeferred, errUncorrected} = 4'h0;
    endtask
    // ==========
    // scenarios
    task automatic t_regs;
        acc(1'h0, ERC_EL3, 64'h0, ERC_OK, 64'h0);
        acc(1'h1, ERC_EL3, '1, ERC_OK, 64'h0);
        acc(1'h0, ERC_EL3, 64'h0, ERC_OK, 64'h10D);
        errorRecordSelector = 1'h1;
        acc(1'h1, ERC_EL3, 64'h4, ERC_OK, 64'h0);
        acc(1'h0, ERC_EL3, 64'h0, ERC_OK, 64'h4);
        check(detectCorrectEnable, 2'h1, "ed per record");
        errorRecordSelector = 1'h0;
        core.issue(1'h1, ERC_EL3, 64'h0, 16'hC2A0);
        check(respValid, 1'h0, "foreign encoding");
    endtask
    task automatic t_traps;
        {el2Enabled, hypErrorRegTrap, monitorErrorRegTrap} = 3'h7;
        acc(1'h1, ERC_EL0, 64'h0, ERC_UNDEF, 64'h0);
        acc(1'h1, ERC_EL1, 64'h0, ERC_TRAP_EL2, 64'h0);
        acc(1'h1, ERC_EL2, 64'h0, ERC_TRAP_EL3, 64'h0);
        {hypErrorRegTrap, fineGrainTrapEnable, fineGrainReadTrap} = 3'h3;
        acc(1'h0, ERC_EL1, 64'h0, ERC_TRAP_EL2, 64'h0);
        acc(1'h1, ERC_EL1, 64'h0, ERC_TRAP_EL3, 64'h0);
        {monitorErrorRegTrap, fineGrainReadTrap, fineGrainWriteTrap} = 3'h1;
        acc(1'h1, ERC_EL1, 64'h0, ERC_TRAP_EL2, 64'h0);
        acc(1'h0, ERC_EL1, 64'h0, ERC_OK, 64'h10D);
        // with the second level off neither its trap bit nor fine grain applies
        {el2Enabled, hypErrorRegTrap, fineGrainReadTrap} = 3'h3;
        acc(1'h0, ERC_EL1, 64'h0, ERC_OK, 64'h10D);
    endtask
    // a cold reset in mid-run clears every enable, counter and flag
    task automatic t_cold;
        @(posedge core_clk);
        #1 sys_rst = 1'h1;
        @(posedge core_clk);
        #1 sys_rst = 1'h0;
        check({detectCorrectEnable, ceOverflows, ceCounts}, 20'h0, "cold reset");
        acc(1'h0, ERC_EL3, 64'h0, ERC_OK, 64'h0);
    endtask
    task automatic t_irqs;
        ev(4'h1, 2'h3);
        ev(4'h5, 2'h2);
        ev(4'hA, 2'h0);
        acc(1'h1, ERC_EL2, 64'h9, ERC_OK, 64'h0);
        ev(4'h1, 2'h2);
        acc(1'h1, ERC_EL2, 64'h5, ERC_OK, 64'h0);
        ev(4'h4, 2'h0);
        acc(1'h1, ERC_EL2, 64'h101, ERC_OK, 64'h0);
        @(posedge core_clk);
        #1 errCorrected = 2'h1;
        repeat (255) @(posedge core_clk);
        #1 check({faultIrq, ceCounts[7:0], ceOverflows}, {1'h1, 8'hFF, 2'h0}, "wrap");
        @(posedge core_clk);
        #1 errCorrected = 2'h0;
        check({ceCounts[7:0], ceOverflows}, 10'h1, "overflow");
    endtask
    initial begin
        sys_rst = 1'h1;
        {el2Enabled, hypErrorRegTrap, monitorErrorRegTrap, errorRecordSelector} = 4'h0;
        {fineGrainTrapEnable, fineGrainReadTrap, fineGrainWriteTrap} = 3'h0;
        {errCorrected, errDeferred, errUncorrected} = 6'h0;
        repeat (5) @(posedge core_clk);
        #1 sys_rst = 1'h0;
        t_regs();
        t_traps();
        t_irqs();
        t_cold();
        finish_test();
    end
    // the tests need well under a thousand cycles
    initial begin
        #200000;
        mismatches++;
        finish_test();
    end
endmodule // error_record_control_reg_test
